// ### src/doc_pkg.sv
// shared constants, types and register map of the digital output conditioner
package doc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ = 40_000_000; // core clock rate in hertz
  localparam int TICK_US = 1000; // delay step, one millisecond
  localparam int TICK_CYCLES = CORE_CLK_HZ / 1_000_000 * TICK_US; // cycles per step
  // pulse-train phase modulus: frequencies are kept in units of 0.01 Hz
  localparam longint unsigned PTO_MOD_L = longint'(CORE_CLK_HZ) * 100;
  localparam logic [32:0] PTO_MOD = PTO_MOD_L[32:0];

  // ----------------------------------------------------------------
  // sizes, limits and reset values
  // ----------------------------------------------------------------
  localparam int NUM_DQ = 4; // digital outputs
  localparam int NUM_EVT = 32; // internal event lines
  localparam int NUM_FBUS = 16; // fieldbus command bits
  localparam logic [15:0] DELAY_MAX_MS = 16'hEA60; // 60000 ms
  localparam logic [15:0] HOLD_MAX_MS = 16'h270F; // 9999 ms
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic signed [31:0] FREQ_MAX = 32'sh05F5E100; // 1e6 Hz in 0.01 Hz
  localparam logic signed [31:0] FREQ_HIGH_RST = 32'sh05F5E100;
  localparam logic signed [31:0] FREQ_LOW_RST = 32'sh00000000;
  localparam logic [15:0] LEVEL_FULL = 16'h8000; // normalised 100 %

  // ----------------------------------------------------------------
  // assignment codes
  // ----------------------------------------------------------------
  localparam logic [5:0] ASG_NONE = 6'h00;
  localparam logic [5:0] ASG_FAULT = 6'h01;
  localparam logic [5:0] ASG_MAINS = 6'h02;
  localparam logic [5:0] ASG_DCCHG = 6'h03;
  localparam logic [5:0] ASG_BRAKE = 6'h04;
  localparam logic [5:0] ASG_OUTCONT = 6'h05;
  localparam int ASG_FBUS_BIT = 5; // set: low four bits pick a fieldbus_cmd_bit

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PTO_MODE_OFS = 8'h00;
  localparam logic [7:0] PTO_HIGH_OFS = 8'h04;
  localparam logic [7:0] PTO_LOW_OFS = 8'h08;
  localparam logic [7:0] PTO_FREQ_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] SHARED_OFS = 8'h14;
  localparam logic [1:0] CHAN_BASE = 2'b01; // channels from 0x40, 0x10 apart
  localparam logic [1:0] CH_ASG_FLD = 2'h0;
  localparam logic [1:0] CH_DELAY_FLD = 2'h1;
  localparam logic [1:0] CH_HOLD_FLD = 2'h2;
  localparam logic [1:0] CH_POL_FLD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTO_OFF = 2'b00,
    PTO_REPEAT = 2'b01,
    PTO_ASSIGNED = 2'b10
  } doc_pto_mode_t;

  typedef enum logic {
    CH_STEADY = 1'b0,
    CH_PENDING = 1'b1
  } doc_ch_state_t;

  typedef struct packed {
    logic [5:0] assign_code; // event source of the output
    logic [15:0] delayMs; // activation delay
    logic [15:0] holdMs; // holding time
    logic activeLow; // negative polarity
  } doc_dq_cfg_t;

endpackage

// ### src/doc_dq_channel.sv
// one digital output: activation delay, holding time and active level
`timescale 1ns/1ps
module doc_dq_channel (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic msTick,
  input wire logic eventIn,
  input wire doc_pkg::doc_dq_cfg_t cfg,
  output logic outState,
  output logic pinLevel
);
  import doc_pkg::*;

  // ----------------------------------------------------------------
  // interval timing
  // ----------------------------------------------------------------
  doc_ch_state_t state; // steady or waiting for an interval
  logic [15:0] msCount; // whole steps seen while pending
  logic [15:0] target; // interval that applies to this change
  logic expired; // interval has run out

  // rising event waits the delay, falling event waits the holding time
  assign target = eventIn ? cfg.delayMs : cfg.holdMs;
  assign expired = (msCount >= target);

  // pending change is timed in step ticks; a zero interval passes at once
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= CH_STEADY;
      msCount <= 16'h0000;
      outState <= 1'b0;
    end else begin
      case (state)
        CH_STEADY: begin
          // a difference between event and output opens an interval
          if (eventIn != outState) begin
            state <= CH_PENDING;
            msCount <= 16'h0000;
          end
        end
        CH_PENDING: begin
          if (eventIn == outState) begin
            // event went back: drop the interval, output stays
            state <= CH_STEADY;
          end else if (expired) begin
            outState <= eventIn;
            state <= CH_STEADY;
          end else if (msTick) begin
            msCount <= msCount + 16'h0001;
          end
        end
        default: begin
          state <= CH_STEADY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // active level
  // ----------------------------------------------------------------
  // positive gives 1 on a true event, negative gives 0
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinLevel <= 1'b0;
    end else begin
      pinLevel <= outState ^ cfg.activeLow;
    end
  end

endmodule

// ### src/doc_output_conditioner.sv
// digital output conditioner top: register slave, outputs and pulse train
// Overview of operation
// - full-scale quantity gives high frequency
// - zero quantity gives low frequency
// - high limit up to 1 MHz, not below low
// - low limit not above high, resets zero
// - current frequency is read-only
// - activation delay 0..60000 ms, reset zero
// - holding time 0..9999 ms, reset zero
// - polarity selects output level for true
// - safety assignments force zero delays, locked
// - safety assignments force positive polarity
// - fieldbus-driven outputs stay on at fault
// - shared input function disables output pin, standard variant only
// - pulse-train function takes over first output, high-power variant only
// - pulse train off, repeat or scaled
`timescale 1ns/1ps
module doc_output_conditioner #(
  parameter int ADDR_W = 8,
  parameter int TICK_CNT = doc_pkg::TICK_CYCLES,
  parameter bit HIGH_POWER = 1'b0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [doc_pkg::NUM_EVT-1:0] eventIn,
  input wire logic [doc_pkg::NUM_FBUS-1:0] fieldbusCmdBit,
  input wire logic [15:0] analogLevel,
  input wire logic ptiPin,
  output logic [doc_pkg::NUM_DQ-1:0] dqOut,
  output logic [doc_pkg::NUM_DQ-1:0] dqOeN,
  output logic ptoPin
);
  import doc_pkg::*;
  localparam int TICK_W = $clog2(TICK_CNT + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CNT - 1);
  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tickCount; // cycles within the current step
  logic msTick; // one-cycle pulse per step
  // free-running divider, so delays carry up to one step of jitter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tickCount <= '0;
      msTick <= 1'b0;
    end else begin
      msTick <= (tickCount == TICK_LAST);
      tickCount <= (tickCount == TICK_LAST) ? '0 : tickCount + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  doc_pto_mode_t ptoMode; // pulse-train mode
  logic signed [31:0] ptoHigh; // frequency at 100 %
  logic signed [31:0] ptoLow; // frequency at 0 %
  logic signed [31:0] ptoFreq; // current frequency, read-only
  logic [1:0] sharedInAsg; // input function on shared pins one and two
  doc_dq_cfg_t cfg [NUM_DQ]; // per output configuration
  logic [NUM_DQ-1:0] chState; // logical output states
  logic [NUM_DQ-1:0] chPin; // conditioned levels
  logic ptoWave; // pulse-train level

  // ----------------------------------------------------------------
  // write channel of the register slave
  // ----------------------------------------------------------------
  logic awHeld; // address taken, waiting for its data
  logic wHeld; // data taken, waiting for its address
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite; // both halves present, commit this cycle
  logic [31:0] wrMask; // byte lanes to update
  logic [31:0] wrOld; // current value at the write address
  logic [31:0] wrData; // merged value to store
  logic wrHit; // write address is mapped
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wrMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
  assign wrData = (wrOld & ~wrMask) | (wDataQ & wrMask);
  // address and data are taken in either order; response after both
  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [31:0] chRead [NUM_DQ][4]; // channel registers as read
  logic [31:0] statusWord;
  assign statusWord = {26'h0000000, ptoWave, HIGH_POWER, chState};
  // returns {hit, value}; if/else chain over the map
  function automatic logic [32:0] regRead(input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h00000000};
    if (a[7:2] == PTO_MODE_OFS[7:2]) begin
      r = {1'b1, 30'h00000000, ptoMode};
    end else if (a[7:2] == PTO_HIGH_OFS[7:2]) begin
      r = {1'b1, ptoHigh};
    end else if (a[7:2] == PTO_LOW_OFS[7:2]) begin
      r = {1'b1, ptoLow};
    end else if (a[7:2] == PTO_FREQ_OFS[7:2]) begin
      r = {1'b1, ptoFreq};
    end else if (a[7:2] == STATUS_OFS[7:2]) begin
      r = {1'b1, statusWord};
    end else if (a[7:2] == SHARED_OFS[7:2]) begin
      r = {1'b1, 30'h00000000, sharedInAsg};
    end else if (a[7:6] == CHAN_BASE) begin
      r = {1'b1, chRead[a[5:4]][a[3:2]]};
    end
    return r;
  endfunction

  assign {wrHit, wrOld} = regRead(awAddrQ);

  // ----------------------------------------------------------------
  // read channel of the register slave
  // ----------------------------------------------------------------
  logic [32:0] rdLook; // hit and value at the read address
  assign rdLook = regRead(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;
  // one read in flight; data captured at the address handshake
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdLook[31:0];
      s_axi_rresp <= rdLook[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pulse-train settings
  // ----------------------------------------------------------------
  logic wrMode, wrHigh, wrLow, wrShared; // strobes per register
  logic highOk, lowOk; // new limit keeps low <= high and the range
  assign wrMode = doWrite && (awAddrQ[7:2] == PTO_MODE_OFS[7:2]);
  assign wrHigh = doWrite && (awAddrQ[7:2] == PTO_HIGH_OFS[7:2]);
  assign wrLow = doWrite && (awAddrQ[7:2] == PTO_LOW_OFS[7:2]);
  assign wrShared = doWrite && (awAddrQ[7:2] == SHARED_OFS[7:2]);
  assign highOk = ($signed(wrData) <= FREQ_MAX) && ($signed(wrData) >= ptoLow);
  assign lowOk = ($signed(wrData) >= -FREQ_MAX) && ($signed(wrData) <= ptoHigh);
  // an out-of-range limit is dropped whole, the old value stays
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptoMode <= PTO_OFF;
      ptoHigh <= FREQ_HIGH_RST;
      ptoLow <= FREQ_LOW_RST;
      sharedInAsg <= 2'b00;
    end else begin
      if (wrMode) begin
        ptoMode <= (wrData[1:0] == 2'b11) ? PTO_OFF : doc_pto_mode_t'(wrData[1:0]);
      end
      if (wrHigh && highOk) begin
        ptoHigh <= $signed(wrData);
      end
      if (wrLow && lowOk) begin
        ptoLow <= $signed(wrData);
      end
      if (wrShared) begin
        sharedInAsg <= wrData[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // frequency scaling
  // ----------------------------------------------------------------
  logic [15:0] levelClamp; // quantity held to 0..100 %
  logic signed [32:0] freqSpan; // high minus low, never negative
  logic signed [49:0] freqProd; // span times level
  logic signed [32:0] freqSum; // low plus scaled span
  logic signed [31:0] nextFreq;
  assign levelClamp = (analogLevel >= LEVEL_FULL) ? LEVEL_FULL : analogLevel;
  assign freqSpan = {ptoHigh[31], ptoHigh} - {ptoLow[31], ptoLow};
  assign freqProd = freqSpan * $signed({1'b0, levelClamp});
  assign freqSum = {ptoLow[31], ptoLow} + freqProd[47:15];
  assign nextFreq = (ptoMode == PTO_ASSIGNED) ? freqSum[31:0] : 32'sh00000000;
  // the register is written by hardware only; bus writes never reach it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptoFreq <= 32'sh00000000;
    end else begin
      ptoFreq <= nextFreq;
    end
  end

  // ----------------------------------------------------------------
  // pulse-train generator
  // ----------------------------------------------------------------
  logic ptiMeta, ptiSync; // pulse-train input synchroniser
  logic [32:0] phaseAcc; // phase in 0.01 Hz cycle units
  logic [31:0] freqMag; // magnitude of the frequency
  logic [33:0] phaseSum;
  logic phaseWrap; // half period reached
  logic ncoWave;
  assign freqMag = ptoFreq[31] ? 32'(-ptoFreq) : ptoFreq;
  assign phaseSum = {1'b0, phaseAcc} + {1'b0, freqMag, 1'b0};
  assign phaseWrap = (phaseSum >= {1'b0, PTO_MOD});
  // two flops for the pin before anything looks at it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptiMeta <= 1'b0;
      ptiSync <= 1'b0;
    end else begin
      ptiMeta <= ptiPin;
      ptiSync <= ptiMeta;
    end
  end

  // twice the frequency is added, so each wrap is one half period
  always_ff @(posedge core_clk) begin
    if (srst || ptoMode != PTO_ASSIGNED) begin
      phaseAcc <= 33'h000000000;
      ncoWave <= 1'b0;
    end else if (phaseWrap) begin
      phaseAcc <= 33'(phaseSum - {1'b0, PTO_MOD});
      ncoWave <= !ncoWave;
    end else begin
      phaseAcc <= phaseSum[32:0];
    end
  end

  // mode selects silence, the repeated input or the scaled wave
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptoWave <= 1'b0;
    end else begin
      case (ptoMode)
        PTO_REPEAT: ptoWave <= ptiSync;
        PTO_ASSIGNED: ptoWave <= ncoWave;
        default: ptoWave <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // digital output channels
  // ----------------------------------------------------------------
  logic [NUM_DQ-1:0] pinOff; // pin released for another function
  logic ptoOnFirst; // pulse train owns the first pin
  logic [NUM_DQ-1:0] nextOut;
  assign ptoOnFirst = HIGH_POWER && (ptoMode != PTO_OFF);
  for (genvar i = 0; i < NUM_DQ; i++) begin : g_dq
    logic chHit, isSafety, srcEvent; // write lands here, safety code, chosen event
    logic [5:0] code;
    assign code = cfg[i].assign_code;
    assign chHit = doWrite && (awAddrQ[7:6] == CHAN_BASE) && (awAddrQ[5:4] == i);
    assign isSafety = (code >= ASG_FAULT) && (code <= ASG_OUTCONT);
    // fieldbus bits pass ungated, so a fault state never clears them
    assign srcEvent = code[ASG_FBUS_BIT] ? (!code[4] && fieldbusCmdBit[code[3:0]])
                                         : eventIn[code[4:0]];

    assign chRead[i][CH_ASG_FLD] = {26'h0000000, code};
    assign chRead[i][CH_DELAY_FLD] = {16'h0000, cfg[i].delayMs};
    assign chRead[i][CH_HOLD_FLD] = {16'h0000, cfg[i].holdMs};
    assign chRead[i][CH_POL_FLD] = {31'h00000000, cfg[i].activeLow};

    // a safety assignment zeroes and locks the delays and polarity
    always_ff @(posedge core_clk) begin
      if (srst) begin
        cfg[i] <= '{ASG_NONE, DELAY_RST, HOLD_RST, 1'b0};
      end else if (chHit && awAddrQ[3:2] == CH_ASG_FLD) begin
        cfg[i].assign_code <= wrData[5:0];
        if (wrData[5:0] >= ASG_FAULT && wrData[5:0] <= ASG_OUTCONT) begin
          cfg[i].delayMs <= 16'h0000;
          cfg[i].holdMs <= 16'h0000;
          cfg[i].activeLow <= 1'b0;
        end
      end else if (chHit && !isSafety) begin
        if (awAddrQ[3:2] == CH_DELAY_FLD && wrData[15:0] <= DELAY_MAX_MS) begin
          cfg[i].delayMs <= wrData[15:0];
        end else if (awAddrQ[3:2] == CH_HOLD_FLD && wrData[15:0] <= HOLD_MAX_MS) begin
          cfg[i].holdMs <= wrData[15:0];
        end else if (awAddrQ[3:2] == CH_POL_FLD) begin
          cfg[i].activeLow <= wrData[0];
        end
      end
    end

    doc_dq_channel u_chan (
      .core_clk(core_clk),
      .srst(srst),
      .msTick(msTick),
      .eventIn(srcEvent && (code != ASG_NONE)),
      .cfg(cfg[i]),
      .outState(chState[i]),
      .pinLevel(chPin[i])
    );
    // pins one and two give way when their input function is assigned, unless HIGH_POWER
    assign pinOff[i] = (i < 2) && !HIGH_POWER && sharedInAsg[i % 2];
    assign nextOut[i] = (i == 0 && ptoOnFirst) ? ptoWave : chPin[i];
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // a released pin is left undriven and low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dqOut <= '0;
      dqOeN <= '1;
      ptoPin <= 1'b0;
    end else begin
      dqOut <= nextOut & ~pinOff;
      dqOeN <= pinOff;
      ptoPin <= ptoWave;
    end
  end

endmodule

// ### sim/doc_output_conditioner_asserts.sv
// bus and pin checks of the output conditioner top
`timescale 1ns/1ps
module doc_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [doc_pkg::NUM_DQ-1:0] dqOut,
  input wire logic [doc_pkg::NUM_DQ-1:0] dqOeN
);
  import doc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // write answer comes two edges after both halves are taken together
  property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  // a hole in the map answers with an error and zero data
  property p_rd_err; s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_rst_oe; $fell(srst) |-> dqOeN == 4'hF && dqOut == 4'h0; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("pins not idle after reset");
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_pin: cover property ($rose(dqOut[0]));
endmodule

bind doc_output_conditioner doc_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dqOut, .dqOeN
);

// ### sim/doc_load_model.sv
// external load wired to each digital output pin
`timescale 1ns/1ps
module doc_load_model (
  input wire logic [doc_pkg::NUM_DQ-1:0] dqOut,
  input wire logic [doc_pkg::NUM_DQ-1:0] dqOeN,
  output logic [doc_pkg::NUM_DQ-1:0] loadOn
);
  import doc_pkg::*;
  // a released pin is pulled down by the load, so it never keeps a stale level
  assign loadOn = dqOut & ~dqOeN;
endmodule

// ### sim/doc_output_conditioner_tb.sv
// self-checking bench of the output conditioner with a load on each pin
`timescale 1ns/1ps
module doc_output_conditioner_tb;
  import doc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TK = 10; // short millisecond keeps delays brief
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1; // answers are always welcome
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, eventIn = 32'h0;
  logic [15:0] fbus = 16'h0;
  logic [15:0] lvl = 16'h0;
  logic pti = 1'b0, pto;
  logic [3:0] dqOut, dqOeN, loadOn;
  logic [31:0] seed = 32'h18, lo, hi;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] rstAdr [6] = '{8'h00, 8'h04, 8'h08, 8'h44, 8'h48, 8'h4C};
  logic [31:0] rstVal [6] = '{32'h0, FREQ_HIGH_RST, 32'h0, 32'h0, 32'h0, 32'h0};
  always #12.5 core_clk = ~core_clk;
  doc_output_conditioner #(.TICK_CNT(TK)) u_dut (
    .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .eventIn, .fieldbusCmdBit(fbus), .analogLevel(lvl),
    .ptiPin(pti), .dqOut, .dqOeN, .ptoPin(pto)
  );
  doc_load_model u_load (.dqOut, .dqOeN, .loadOn);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected pulse-train frequency, floored like an arithmetic shift
  function automatic logic [31:0] scl(input logic [31:0] l, h, input logic [15:0] v);
    longint k;
    k = (v > 16'h8000) ? 32768 : longint'(v);
    return 32'(longint'($signed(l)) + (((longint'($signed(h)) - $signed(l)) * k) >>> 15));
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready and answer are taken at the edge that hands them over
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", (a == 8'h18) ? RESP_SLVERR : RESP_OKAY, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rresp", (a == 8'h18) ? RESP_SLVERR : RESP_OKAY, s_axi_rresp);
    chk("rdata", e, s_axi_rdata);
  endtask
  task automatic pin(input int n, input logic [3:0] e);
    repeat (n) @(posedge core_clk);
    chk("load", 32'(e), 32'(loadOn));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    foreach (rstAdr[i]) rd(rstAdr[i], rstVal[i]);
    $display("reset values done");
    lo = 32'h0 - (nxt() % 32'h05F5E100);
    hi = nxt() % 32'h05F5E100;
    wr(8'h00, 32'h2);
    wr(8'h08, lo);
    wr(8'h04, hi);
    wr(8'h08, hi + 32'h1);
    wr(8'h04, lo - 32'h1);
    wr(8'h04, 32'h05F5E101);
    rd(8'h08, lo);
    rd(8'h04, hi);
    wr(8'h0C, 32'h0);
    for (int i = 0; i < 8; i++) begin
      lvl <= (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : 16'(nxt() % 32'h8001);
      repeat (2) @(posedge core_clk);
      rd(8'h0C, scl(lo, hi, lvl));
    end
    wr(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h00, 32'h1);
    pti <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("pto", 32'h1, 32'(pto));
    $display("pulse train scaling done");
    wr(8'h40, 32'h6);
    wr(8'h44, 32'h3);
    wr(8'h48, 32'h2);
    eventIn[6] <= 1'b1;
    pin(15, 4'h0);
    eventIn[6] <= 1'b0;
    pin(50, 4'h0);
    eventIn[6] <= 1'b1;
    pin(50, 4'h1);
    eventIn[6] <= 1'b0;
    pin(5, 4'h1);
    pin(40, 4'h0);
    $display("delays done");
    wr(8'h64, 32'h5);
    wr(8'h6C, 32'h1);
    wr(8'h60, 32'h1);
    wr(8'h68, 32'h7);
    rd(8'h64, 32'h0);
    rd(8'h68, 32'h0);
    rd(8'h6C, 32'h0);
    eventIn[1] <= 1'b1;
    pin(6, 4'h4);
    wr(8'h70, 32'h20);
    fbus[0] <= 1'b1;
    pin(6, 4'hC);
    wr(8'h5C, 32'h1);
    pin(6, 4'hE);
    wr(8'h14, 32'h2);
    pin(3, 4'hC);
    chk("oe", 32'h2, 32'(dqOeN));
    wr(8'h18, 32'h1);
    rd(8'h18, 32'h0);
    $display("safety, polarity and shared pins done");
    stop_test();
  end
endmodule
